// ===== hdl/spx_core.sv
// Purpose: one-channel full-duplex serial transfer core, master or slave
// Assumes: clock mode 0 (idle low, sample rising, change falling), APB slave
// Notes: pins pass two flip-flops; keep master divider ratio at 8 or more
// Functional notes
// - master drives mosi, slave drives miso
// - master clock runs only during a frame
// - receive-only master sends configurable dummy frames
// - normal mode waits for data read
// - high-speed mode starts next frame at once
// - auto-stop halts clock while data unread
// - overrun flagged when new frame dropped while data unread
// - slave shifts only on external clocks
// - slave transmit path double buffered
// - next transmit word accepted while shifting
// - slave without data sends dummy pattern
// - transmit-empty and receive-full requests raised
// - error request with four status flags
// - 16-bit little-endian leaves byte1 then byte0
// - 32-bit leaves byte3 first, optional swap
// - 8-bit frames leave as stored
// - requests usable as transfer-controller triggers
// - length 8..16, 20, 24, 32; msb/lsb first
// - master clock divides by 2 to 4096
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module spx_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire spx_pkg::spx_pins_t pins_i,
    output logic sclk_o,
    output logic sclk_oe,
    output logic mosi_o,
    output logic mosi_oe,
    output logic miso_o,
    output logic miso_oe,
    output logic ssl_n_o,
    output logic tx_empty_irq,
    output logic rx_full_irq,
    output logic error_irq
);
    import spx_pkg::*;

    typedef enum logic {ST_IDLE, ST_SHIFT} spx_state_t;

    // ----------------------------------------
    // state
    // ----------------------------------------
    spx_ctrl_t ctrl_ff;
    spx_stat_t stat, clr;
    spx_pins_t sy1_ff, sy2_ff;
    spx_state_t st_ff;
    logic [31:0] dummy_ff, tx_buf_ff, rx_buf_ff, sh_ff, rx_sh_ff, prdata_ff;
    logic [BAUD_W-1:0] baud_ff, div_ff;
    logic tx_valid_ff, rx_full_ff, sclk_ff, sclk_d_ff, par_tx_ff, rx_par_ff;
    logic ovr_ff, mode_fault_flag_ff, udr_ff, par_ff;
    logic [5:0] bit_cnt_ff;

    logic wr, rd, mapped, rd_data, wr_data;
    logic [5:0] len, total;
    logic [31:0] mask, src, rx_word;
    logic tick, stall, rise, fall, sample, shift, done, load, go, reload, abort;
    logic m_go, s_go, mode_fault_flag_evt, rx_ok, par_bad;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || (paddr == OFS_DATA) ||
                    (paddr == OFS_DUMMY) || (paddr == OFS_BAUD);
    assign wr = psel && penable && pwrite && mapped;
    assign rd = psel && penable && !pwrite && mapped;
    assign wr_data = wr && (paddr == OFS_DATA);
    assign rd_data = rd && (paddr == OFS_DATA);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_ff;
    // write-one-to-clear strobes, laid out like the status word
    assign clr = spx_stat_t'((wr && paddr == OFS_STAT) ? pwdata : 32'h00000000);

    always_comb begin
        stat = '0;
        stat.busy = (st_ff == ST_SHIFT);
        stat.tx_empty = !tx_valid_ff;
        stat.rx_full = rx_full_ff;
        stat.parity_error_flag = par_ff;
        stat.underrun_flag = udr_ff;
        stat.mode_fault_flag = mode_fault_flag_ff;
        stat.overrun_flag = ovr_ff;
    end

    // read data captured in the setup phase so it is stable at the access edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_ff <= '0;
        end else if (psel && !penable) begin
            case (paddr)
                OFS_CTRL: prdata_ff <= ctrl_ff;
                OFS_STAT: prdata_ff <= stat;
                OFS_DATA: prdata_ff <= rx_buf_ff;
                OFS_DUMMY: prdata_ff <= dummy_ff;
                OFS_BAUD: prdata_ff <= {{(32-BAUD_W){1'b0}}, baud_ff};
                default: prdata_ff <= '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= '0;
            dummy_ff <= DUMMY_RST;
            baud_ff <= BAUD_RST;
        end else if (wr) begin
            if (paddr == OFS_CTRL) ctrl_ff <= pwdata & CTRL_MASK;
            if (paddr == OFS_DUMMY) dummy_ff <= pwdata;
            if (paddr == OFS_BAUD) baud_ff <= pwdata[BAUD_W-1:0];
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sy1_ff <= '0;
            sy2_ff <= '0;
            sclk_d_ff <= 1'b0;
        end else begin
            sy1_ff <= pins_i;
            sy2_ff <= sy1_ff;
            sclk_d_ff <= sy2_ff.sclk;
        end
    end

    // ----------------------------------------
    // frame shaping
    // ----------------------------------------
    assign len = spx_frame_len(ctrl_ff.len_code);
    assign total = len + {5'd0, ctrl_ff.par_en};
    assign mask = 32'hFFFFFFFF >> (6'd32 - len);

    // little-endian words leave high byte first unless swapped
    function automatic logic [31:0] order(input logic [31:0] w, input logic [5:0] n,
                                          input logic sw);
        logic [31:0] r;
        r = w;
        if (sw && n == LEN_16) r = {16'h0000, w[7:0], w[15:8]};
        if (sw && n == LEN_32) r = {w[7:0], w[15:8], w[23:16], w[31:24]};
        return r;
    endfunction

    // slave without fresh data falls back to the dummy pattern
    assign src = order(tx_valid_ff ? tx_buf_ff : dummy_ff, len, ctrl_ff.swap) & mask;
    assign rx_word = order(ctrl_ff.lsb_first ? (rx_sh_ff >> (6'd32 - len)) : (rx_sh_ff & mask),
                           len, ctrl_ff.swap);
    assign par_bad = ctrl_ff.par_en && ((^rx_word) != rx_par_ff);

    // ----------------------------------------
    // serial clock and edges
    // ----------------------------------------
    // auto-stop parks the clock low before the last sampling edge
    assign stall = ctrl_ff.autostop && rx_full_ff && !sclk_ff &&
                   (bit_cnt_ff == total - 6'd1);
    assign tick = (div_ff == baud_ff) && !stall;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_ff <= '0;
        end else if (st_ff != ST_SHIFT || !ctrl_ff.master || tick) begin
            div_ff <= '0;
        end else if (!stall) begin
            div_ff <= div_ff + 1'b1;
        end
    end

    assign rise = ctrl_ff.master ? (tick && !sclk_ff) : (sy2_ff.sclk && !sclk_d_ff);
    assign fall = ctrl_ff.master ? (tick && sclk_ff) : (!sy2_ff.sclk && sclk_d_ff);
    assign sample = (st_ff == ST_SHIFT) && rise;
    assign shift = (st_ff == ST_SHIFT) && fall;
    // a cut frame never completes, so it cannot land in the receive buffer
    assign done = shift && !abort && (bit_cnt_ff + 6'd1 == total);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_ff <= 1'b0;
        end else if (st_ff != ST_SHIFT || !ctrl_ff.master || abort) begin
            sclk_ff <= 1'b0;
        end else if (tick) begin
            sclk_ff <= !sclk_ff;
        end
    end

    // ----------------------------------------
    // frame sequencing
    // ----------------------------------------
    assign mode_fault_flag_evt = ctrl_ff.en && ctrl_ff.master && !sy2_ff.ss_n;
    assign rx_ok = ctrl_ff.hs_mode || !rx_full_ff;
    assign m_go = ctrl_ff.en && ctrl_ff.master && !mode_fault_flag_evt &&
                  (tx_valid_ff || ctrl_ff.rx_only) && rx_ok;
    assign s_go = ctrl_ff.en && !ctrl_ff.master && !sy2_ff.ss_n;
    assign go = ctrl_ff.master ? m_go : s_go;
    assign reload = ctrl_ff.master ? (m_go && ctrl_ff.hs_mode) : s_go;
    assign abort = !ctrl_ff.en || mode_fault_flag_evt || (!ctrl_ff.master && sy2_ff.ss_n);
    assign load = !abort && ((st_ff == ST_IDLE && go) || (done && reload));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= ST_IDLE;
        end else begin
            case (st_ff)
                ST_IDLE: if (load) st_ff <= ST_SHIFT;
                ST_SHIFT: if (abort || (done && !load)) st_ff <= ST_IDLE;
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh_ff <= '0;
            par_tx_ff <= 1'b0;
            bit_cnt_ff <= '0;
        end else if (load) begin
            sh_ff <= ctrl_ff.lsb_first ? src : (src << (6'd32 - len));
            par_tx_ff <= ^src;
            bit_cnt_ff <= '0;
        end else if (shift) begin
            sh_ff <= ctrl_ff.lsb_first ? (sh_ff >> 1) : (sh_ff << 1);
            bit_cnt_ff <= bit_cnt_ff + 6'd1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_sh_ff <= '0;
            rx_par_ff <= 1'b0;
        end else if (sample && bit_cnt_ff >= len) begin
            rx_par_ff <= ctrl_ff.master ? sy2_ff.miso : sy2_ff.mosi;
        end else if (sample) begin
            rx_sh_ff <= ctrl_ff.lsb_first ?
                {(ctrl_ff.master ? sy2_ff.miso : sy2_ff.mosi), rx_sh_ff[31:1]} :
                {rx_sh_ff[30:0], (ctrl_ff.master ? sy2_ff.miso : sy2_ff.mosi)};
        end
    end

    // ----------------------------------------
    // buffers
    // ----------------------------------------
    // a write in the load cycle wins, so the new word is not lost
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_buf_ff <= '0;
            tx_valid_ff <= 1'b0;
        end else if (wr_data) begin
            tx_buf_ff <= pwdata;
            tx_valid_ff <= 1'b1;
        end else if (load) begin
            tx_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_buf_ff <= '0;
            rx_full_ff <= 1'b0;
        end else if (done && (!rx_full_ff || rd_data)) begin
            rx_buf_ff <= rx_word;
            rx_full_ff <= 1'b1;
        end else if (rd_data) begin
            rx_full_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // error flags, write one to clear, set wins
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovr_ff <= 1'b0;
            mode_fault_flag_ff <= 1'b0;
            udr_ff <= 1'b0;
            par_ff <= 1'b0;
        end else begin
            // new frame dropped, unread one kept
            ovr_ff <= (done && rx_full_ff && !rd_data) ||
                      (ovr_ff && !clr.overrun_flag);
            mode_fault_flag_ff <= mode_fault_flag_evt || (mode_fault_flag_ff && !clr.mode_fault_flag);
            udr_ff <= (load && !ctrl_ff.master && !tx_valid_ff && !ctrl_ff.rx_only) ||
                      (udr_ff && !clr.underrun_flag);
            par_ff <= (done && par_bad) ||
                      (par_ff && !clr.parity_error_flag);
        end
    end

    // ----------------------------------------
    // requests and pins
    // ----------------------------------------
    assign tx_empty_irq = ctrl_ff.en && !tx_valid_ff;
    assign rx_full_irq = rx_full_ff;
    assign error_irq = ovr_ff || mode_fault_flag_ff || udr_ff || par_ff;

    assign sclk_o = sclk_ff;
    assign sclk_oe = ctrl_ff.en && ctrl_ff.master;
    assign ssl_n_o = !(ctrl_ff.en && ctrl_ff.master && st_ff == ST_SHIFT);
    assign mosi_o = (bit_cnt_ff >= len) ? par_tx_ff :
                    (ctrl_ff.lsb_first ? sh_ff[0] : sh_ff[31]);
    assign mosi_oe = ctrl_ff.en && ctrl_ff.master;
    assign miso_o = mosi_o;
    assign miso_oe = ctrl_ff.en && !ctrl_ff.master && !sy2_ff.ss_n;

endmodule

// ===== hdl/spx_pkg.sv
// Purpose: shared constants and types of the serial transfer core
// Assumes: 32-bit APB data, byte offsets below are byte addresses
// Notes: one aligned word per register, reserved bits read as zero
package spx_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_DUMMY = 8'h0C;
    localparam logic [7:0] OFS_BAUD = 8'h10;

    localparam int BAUD_W = 11;
    localparam logic [31:0] CTRL_MASK = 32'h00000FFF;
    localparam logic [31:0] DUMMY_RST = 32'hFFFFFFFF;
    localparam logic [BAUD_W-1:0] BAUD_RST = 11'h000;

    // ----------------------------------------
    // field layouts
    // ----------------------------------------
    typedef struct packed {
        logic [19:0] rsvd;
        logic [3:0] len_code;
        logic swap;
        logic par_en;
        logic rx_only;
        logic lsb_first;
        logic autostop;
        logic hs_mode;
        logic master;
        logic en;
    } spx_ctrl_t;

    typedef struct packed {
        logic [24:0] rsvd;
        logic busy;
        logic tx_empty;
        logic rx_full;
        logic parity_error_flag;
        logic underrun_flag;
        logic mode_fault_flag;
        logic overrun_flag;
    } spx_stat_t;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic miso;
        logic ss_n;
    } spx_pins_t;

    // ----------------------------------------
    // frame length
    // ----------------------------------------
    localparam logic [3:0] LEN_CODE_16 = 4'h8;
    localparam logic [5:0] LEN_BASE = 6'd8;
    localparam logic [5:0] LEN_16 = 6'd16;
    localparam logic [5:0] LEN_20 = 6'd20;
    localparam logic [5:0] LEN_24 = 6'd24;
    localparam logic [5:0] LEN_32 = 6'd32;

    function automatic logic [5:0] spx_frame_len(input logic [3:0] code);
        logic [5:0] n;
        n = LEN_32;
        if (code <= LEN_CODE_16) begin
            n = LEN_BASE + {2'b00, code};
        end else if (code == 4'h9) begin
            n = LEN_20;
        end else if (code == 4'hA) begin
            n = LEN_24;
        end
        return n;
    endfunction

endpackage

// ===== test/spx_core_sva.sv
// Purpose: port-level checks of the serial transfer core
// Assumes: master in clock mode 0, zero-wait apb
// Notes: bound to every core instance
`timescale 1ns/1ns
module spx_core_sva
    import spx_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire spx_pkg::spx_pins_t pins_i,
    input wire logic sclk_o,
    input wire logic sclk_oe,
    input wire logic mosi_o,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ssl_n_o,
    input wire logic rx_full_irq,
    input wire logic error_irq
);
    // --------------------
    // port relations
    // --------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence data_read_s;
        psel && penable && !pwrite && paddr == OFS_DATA;
    endsequence
    sequence stat_clear_s;
        psel && penable && pwrite && paddr == OFS_STAT && pwdata[3:0] == 4'hF;
    endsequence
    chk_oe_exclusive: assert property (!(mosi_oe && miso_oe))
        else $error("mosi and miso both driven");
    chk_frame_mosi: assert property (!ssl_n_o |-> mosi_oe)
        else $error("frame without mosi drive");
    chk_clock_in_frame: assert property ($rose(sclk_o) |-> !ssl_n_o && sclk_oe)
        else $error("serial clock outside frame");
    chk_mosi_hold: assert property (sclk_o && $past(sclk_o) |-> $stable(mosi_o))
        else $error("mosi moved while clock high");
    chk_rx_held: assert property (
        rx_full_irq && !(psel && penable && !pwrite && paddr == OFS_DATA) |=> rx_full_irq)
        else $error("rx flag lost before read");
    chk_read_clears: assert property (data_read_s ##0 (ssl_n_o && !miso_oe) |=> !rx_full_irq)
        else $error("rx flag kept after read");
    chk_error_held: assert property (
        error_irq && !(psel && penable && pwrite && paddr == OFS_STAT) |=> error_irq)
        else $error("error dropped without clear");
    chk_w1c_clear: assert property (
        stat_clear_s ##0 (ssl_n_o && !miso_oe && $past(pins_i.ss_n, 2) && $past(pins_i.ss_n, 3))
        |=> !error_irq)
        else $error("error kept after clear");
endmodule
bind spx_core spx_core_sva spx_core_sva_i (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pins_i(pins_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ssl_n_o(ssl_n_o),
    .rx_full_irq(rx_full_irq), .error_irq(error_irq));

// ===== test/spx_core_test.sv
// Purpose: self-checking bench of the core working as master and slave
// Assumes: zero-wait apb, mode 0 slave model on the pins
// Notes: bench plays the external master on the slave pins
`timescale 1ns/1ns
module spx_core_test;
    import spx_pkg::*;
    // --------------------
    // bench
    // --------------------
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, s_tx = 32'hC35A, prdata, rd_q, s_rx;
    logic [5:0] s_len = 6'd16;
    logic pready, pslverr, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ssl_n_o;
    logic tx_empty_irq, rx_full_irq, error_irq, s_miso, rd_err;
    logic m_sclk = 1'b0, m_mosi = 1'b0, m_ss_n = 1'b1;
    spx_pins_t pins;
    int failures = 0, checks = 0;
    assign pins = {m_sclk, m_mosi, s_miso, m_ss_n};
    spx_core spx_core_i (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins_i(pins), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_o(miso_o), .miso_oe(miso_oe), .ssl_n_o(ssl_n_o), .tx_empty_irq(tx_empty_irq),
        .rx_full_irq(rx_full_irq), .error_irq(error_irq));
    spx_slave_model spx_slave_model_i (.sclk(sclk_o), .ss_n(ssl_n_o), .mosi(mosi_o),
        .tx_word(s_tx), .len(s_len), .miso(s_miso), .rx_bits(s_rx));
    initial begin
        forever begin
            #5 clk = ~clk;
        end
    end
    task automatic finish_test;
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failures++;
            finish_test();
        end
        rd_q = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_for(input logic err);
        int n;
        n = 0;
        while ((err ? error_irq : rx_full_irq) !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 3000) begin
                failures++;
                finish_test();
            end
        end
    endtask
    task automatic t_reset;
        apb(1'b0, OFS_DUMMY, 32'h0);
        cmp("dummy", DUMMY_RST, rd_q);
        apb(1'b0, 8'h40, 32'h0);
        cmp("unmapped", 32'h1, {31'h0, rd_err});
        cmp("irqs", 32'h0, {29'h0, tx_empty_irq, rx_full_irq, error_irq});
    endtask
    task automatic t_master16;
        apb(1'b1, OFS_BAUD, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h803);
        cmp("tx empty", 32'h1, {31'h0, tx_empty_irq});
        apb(1'b1, OFS_DATA, 32'hAABB);
        wait_for(1'b0);
        cmp("mosi16", 32'hAABB, s_rx & 32'hFFFF);
        cmp("clk parked", 32'h0, {31'h0, sclk_o});
        apb(1'b0, OFS_DATA, 32'h0);
        cmp("rx16", 32'hC35A, rd_q & 32'hFFFF);
    endtask
    task automatic t_order32;
        s_len = 6'd32;
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, OFS_CTRL, (s != 0) ? 32'hB83 : 32'hB03);
            apb(1'b1, OFS_DATA, 32'h11223344);
            wait_for(1'b0);
            cmp("mosi32", (s != 0) ? 32'h44332211 : 32'h11223344, s_rx);
            apb(1'b0, OFS_DATA, 32'h0);
        end
    endtask
    task automatic t_overrun;
        s_len = 6'd16;
        apb(1'b1, OFS_CTRL, 32'h807);
        apb(1'b1, OFS_DATA, 32'h1234);
        apb(1'b1, OFS_DATA, 32'h5678);
        wait_for(1'b1);
        cmp("mosi next", 32'h5678, s_rx & 32'hFFFF);
        apb(1'b0, OFS_STAT, 32'h0);
        cmp("overrun", 32'h1, rd_q & 32'h1);
        apb(1'b0, OFS_DATA, 32'h0);
        cmp("kept", 32'hC35A, rd_q & 32'hFFFF);
        apb(1'b1, OFS_STAT, 32'hF);
        cmp("err clr", 32'h0, {31'h0, error_irq});
    endtask
    task automatic t_rx_only;
        s_len = 6'd8;
        apb(1'b1, OFS_DUMMY, 32'h1E);
        apb(1'b1, OFS_CTRL, 32'h033);
        wait_for(1'b0);
        cmp("dummy lsb", 32'h78, s_rx & 32'hFF);
        apb(1'b0, OFS_DATA, 32'h0);
        cmp("rx lsb", 32'h5A, rd_q);
        apb(1'b1, OFS_CTRL, 32'h0);
    endtask
    task automatic t_autostop;
        s_len = 6'd16;
        apb(1'b1, OFS_CTRL, 32'h80F);
        apb(1'b1, OFS_DATA, 32'h1234);
        apb(1'b1, OFS_DATA, 32'h5678);
        repeat (400) @(posedge clk);
        cmp("stopped", 32'h0, {31'h0, error_irq});
        apb(1'b0, OFS_DATA, 32'h0);
        cmp("first", 32'hC35A, rd_q);
        wait_for(1'b0);
        apb(1'b0, OFS_DATA, 32'h0);
        cmp("second", 32'h3CA5, rd_q);
        apb(1'b1, OFS_CTRL, 32'h0);
    endtask
    // one mode 0 frame of 8 bits, msb first, as an external master
    task automatic slv_frame(input logic [7:0] out, input logic [7:0] exp);
        logic [7:0] got;
        got = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            m_mosi <= out[i];
            repeat (6) @(posedge clk);
            got[i] = miso_o;
            m_sclk <= 1'b1;
            repeat (6) @(posedge clk);
            m_sclk <= 1'b0;
        end
        // synchroniser delay before the frame is complete inside
        repeat (6) @(posedge clk);
        cmp("miso", {24'h0, exp}, {24'h0, got});
    endtask
    // relies on the dummy pattern 1E left by the receive-only scenario
    task automatic t_slave;
        apb(1'b1, OFS_DATA, 32'hA5);
        apb(1'b1, OFS_CTRL, 32'h001);
        m_ss_n <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b1, OFS_DATA, 32'h3C);
        cmp("slave oe", 32'h2, {30'h0, miso_oe, mosi_oe});
        slv_frame(8'h96, 8'hA5);
        apb(1'b0, OFS_DATA, 32'h0);
        cmp("slave rx", 32'h96, rd_q);
        slv_frame(8'h69, 8'h3C);
        apb(1'b0, OFS_DATA, 32'h0);
        cmp("slave rx2", 32'h69, rd_q);
        slv_frame(8'h0F, 8'h1E);
        apb(1'b0, OFS_DATA, 32'h0);
        cmp("slave rx3", 32'h0F, rd_q);
        apb(1'b1, OFS_CTRL, 32'h003);
        apb(1'b0, OFS_STAT, 32'h0);
        cmp("err flags", 32'h6, rd_q & 32'hF);
        m_ss_n <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_STAT, 32'hF);
        cmp("flags clr", 32'h0, {31'h0, error_irq});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_master16();
        t_order32();
        t_overrun();
        t_autostop();
        t_rx_only();
        t_slave();
        finish_test();
    end
endmodule

// ===== test/spx_slave_model.sv
// Purpose: behavioural slave on the far side of the serial pins
// Assumes: clock mode 0, msb first, frame length set by the bench
// Notes: gapless frames answer with the inverted word
`timescale 1ns/1ns
module spx_slave_model (
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic [31:0] tx_word,
    input wire logic [5:0] len,
    output logic miso,
    output logic [31:0] rx_bits
);
    // --------------------
    // shifter
    // --------------------
    logic [31:0] cur = 32'h0;
    int cnt = 0;
    initial begin
        miso = 1'b0;
        rx_bits = 32'h0;
    end
    always @(negedge ss_n) begin
        cnt = 0;
        cur = tx_word;
        miso = tx_word[len - 6'd1];
    end
    // released line must not keep showing the last bit
    always @(posedge ss_n) begin
        miso = ~miso;
    end
    always @(posedge sclk) begin
        rx_bits = {rx_bits[30:0], mosi};
        cnt = cnt + 1;
        if (cnt == int'(len)) begin
            cnt = 0;
            cur = ~cur;
        end
    end
    always @(negedge sclk) begin
        if (!ss_n) begin
            miso = cur[int'(len) - 1 - cnt];
        end
    end
endmodule
